// >>> arpf_defines.svh
// constants of the asynchronous receive packet formatter
`ifndef ARPF_DEFINES_SVH
`define ARPF_DEFINES_SVH
`define ARPF_TC_QWR_REQ 4'h0
`define ARPF_TC_BWR_REQ 4'h1
`define ARPF_TC_WR_RSP 4'h2
`define ARPF_TC_QRD_REQ 4'h4
`define ARPF_TC_BRD_REQ 4'h5
`define ARPF_TC_QRD_RSP 4'h6
`define ARPF_TC_BRD_RSP 4'h7
`define ARPF_TC_LOCK_REQ 4'h9
`define ARPF_TC_STREAM 4'hA
`define ARPF_TC_LOCK_RSP 4'hB
`define ARPF_ACK_COMPLETE 4'h1
`define ARPF_ACK_PENDING 4'h2
`define ARPF_ACK_BUSY_X 4'h4
`define ARPF_ACK_BUSY_A 4'h5
`define ARPF_ACK_BUSY_B 4'h6
`define ARPF_ACK_DATA_ERR 4'hD
`define ARPF_ACK_TYPE_ERR 4'hE
`define ARPF_STRM_OK 4'h1
`define ARPF_STRM_BAD 4'hD
`define ARPF_TRL_U_BIT 16
`define ARPF_LAST_NODATA 2'h2
`define ARPF_LAST_QUAD 2'h3
`define ARPF_LAST_BLOCK 2'h3
`define ARPF_LAST_STREAM 2'h0
`define ARPF_REG_CTRL 12'h000
`define ARPF_REG_STAT 12'h004
`define ARPF_REG_MASK 12'h008
`define ARPF_REG_COUNT 12'h00C
`define ARPF_REG_LAST 12'h010
`define ARPF_CTRL_RST 1'h1
`define ARPF_EV_STORED 0
`define ARPF_EV_DERR 1
`define ARPF_EV_RSVACK 2
`define ARPF_EV_W 3
`endif

// >>> arpf_pkg.sv
// types of the asynchronous receive packet formatter
`default_nettype none
package arpf_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY, ST_TRL} arpf_state_t;
    typedef enum logic [1:0] {FMT_NODATA, FMT_QUAD, FMT_BLOCK, FMT_STREAM} arpf_fmt_t;
    typedef struct packed {
        logic [15:0] dest_id;
        logic [5:0] transaction_label;
        logic [1:0] retry_code;
        logic [3:0] transaction_kind_code;
        logic [3:0] priority_lvl;
        logic [15:0] source_id;
        logic [47:0] dest_offset;
        logic [3:0] response_code_field;
        logic [31:0] quadlet_data;
        logic [15:0] data_length;
        logic [15:0] lock_action_code;
        logic [1:0] stream_tag;
        logic [5:0] stream_channel;
        logic [3:0] stream_sync;
        logic unsolicited;
        logic [3:0] returned_ack_field;
    } arpf_hdr_t;
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic crc_err;
    } arpf_byte_t;
endpackage : arpf_pkg
`default_nettype wire

// >>> arpf_formatter.sv
// receive formatter: received packets to quadlets for the receive fifo
//
// The APB slave port and the placing of the registers are this design's own decisions.
`include "arpf_defines.svh"
`default_nettype none
module arpf_formatter
    import arpf_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic hdr_valid, // received header offered
    input wire arpf_hdr_t hdr_in, // received header fields
    output logic hdr_ready, // header may be taken
    input wire logic byte_valid, // payload byte offered
    input wire arpf_byte_t byte_in, // payload byte, last, crc error
    output logic byte_ready, // payload byte may be taken
    input wire logic fifo_full, // fifo refuses a write this cycle
    output logic fifo_wr, // fifo write strobe
    output logic [31:0] fifo_data, // fifo write quadlet
    output logic irq // level interrupt
);
    // ****************************************
    // decoding helpers
    // ****************************************
    function automatic arpf_fmt_t fmt_of(input logic [3:0] tc);
        case (tc)
            `ARPF_TC_QRD_REQ, `ARPF_TC_WR_RSP: fmt_of = FMT_NODATA;
            `ARPF_TC_QWR_REQ, `ARPF_TC_QRD_RSP, `ARPF_TC_BRD_REQ: fmt_of = FMT_QUAD;
            `ARPF_TC_BWR_REQ, `ARPF_TC_BRD_RSP: fmt_of = FMT_BLOCK;
            `ARPF_TC_LOCK_REQ, `ARPF_TC_LOCK_RSP: fmt_of = FMT_BLOCK;
            `ARPF_TC_STREAM: fmt_of = FMT_STREAM;
            default: fmt_of = FMT_NODATA;
        endcase
    endfunction : fmt_of

    function automatic logic is_resp(input logic [3:0] tc);
        is_resp = (tc == `ARPF_TC_WR_RSP) || (tc == `ARPF_TC_QRD_RSP) ||
                  (tc == `ARPF_TC_BRD_RSP) || (tc == `ARPF_TC_LOCK_RSP);
    endfunction : is_resp

    function automatic logic is_lock(input logic [3:0] tc);
        is_lock = (tc == `ARPF_TC_LOCK_REQ) || (tc == `ARPF_TC_LOCK_RSP);
    endfunction : is_lock

    function automatic logic is_rsv_ack(input logic [3:0] a);
        case (a)
            `ARPF_ACK_COMPLETE, `ARPF_ACK_PENDING: is_rsv_ack = 1'b0;
            `ARPF_ACK_BUSY_X, `ARPF_ACK_BUSY_A, `ARPF_ACK_BUSY_B: is_rsv_ack = 1'b0;
            `ARPF_ACK_DATA_ERR, `ARPF_ACK_TYPE_ERR: is_rsv_ack = 1'b0;
            default: is_rsv_ack = 1'b1;
        endcase
    endfunction : is_rsv_ack

    function automatic logic [1:0] last_idx(input arpf_fmt_t f);
        case (f)
            FMT_QUAD: last_idx = `ARPF_LAST_QUAD;
            FMT_BLOCK: last_idx = `ARPF_LAST_BLOCK;
            FMT_STREAM: last_idx = `ARPF_LAST_STREAM;
            default: last_idx = `ARPF_LAST_NODATA;
        endcase
    endfunction : last_idx

    function automatic logic [31:0] hdr_quad(input arpf_hdr_t h, input arpf_fmt_t f,
                                             input logic [1:0] i);
        logic [3:0] tc;
        tc = h.transaction_kind_code;
        case (i)
            2'h0: begin
                if (f == FMT_STREAM) begin
                    hdr_quad = {h.data_length, h.stream_tag, h.stream_channel, tc,
                                h.stream_sync};
                end else begin
                    hdr_quad = {h.dest_id, h.transaction_label, h.retry_code, tc,
                                h.priority_lvl};
                end
            end
            2'h1: begin
                if (is_resp(tc)) begin
                    hdr_quad = {h.source_id, h.response_code_field, 12'h000};
                end else begin
                    hdr_quad = {h.source_id, h.dest_offset[47:32]};
                end
            end
            2'h2: hdr_quad = is_resp(tc) ? 32'h0000_0000 : h.dest_offset[31:0];
            default: begin
                if (f == FMT_BLOCK) begin
                    hdr_quad = {h.data_length, is_lock(tc) ? h.lock_action_code : 16'h0000};
                end else if (tc == `ARPF_TC_BRD_REQ) begin
                    hdr_quad = {h.data_length, 16'h0000};
                end else begin
                    hdr_quad = h.quadlet_data;
                end
            end
        endcase
    endfunction : hdr_quad

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `ARPF_REG_CTRL) || (a == `ARPF_REG_STAT) || (a == `ARPF_REG_MASK) ||
                  (a == `ARPF_REG_COUNT) || (a == `ARPF_REG_LAST);
    endfunction : addr_ok

    // ****************************************
    // state
    // ****************************************
    arpf_state_t st_r, st_nxt;
    arpf_fmt_t fmt_r;
    arpf_hdr_t hdr_r;
    logic [1:0] idx_r, idx_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [1:0] bcnt_r, bcnt_nxt;
    logic [15:0] tot_r, tot_nxt;
    logic pend_r, pend_nxt;
    logic done_r, done_nxt;
    logic err_r, err_nxt;
    logic emit, emit_trl, emit_hdr, take, stor;
    logic [31:0] emit_data;
    logic [3:0] ack_fin;
    logic [31:0] trl_q;
    logic has_pay, accept;
    logic wr_trl_r, wr_hdr_r;
    logic [1:0] wr_idx_r;
    logic ctrl_en_r;
    logic [`ARPF_EV_W-1:0] sts_r, sts_nxt, mask_r, ev;
    logic [31:0] count_r;
    logic [7:0] last_r;
    logic apb_acc, apb_wr;

    assign accept = hdr_valid && hdr_ready;
    assign has_pay = ((fmt_r == FMT_BLOCK) || (fmt_r == FMT_STREAM)) &&
                     (hdr_r.data_length != 16'h0000);
    assign take = byte_valid && byte_ready;
    assign stor = tot_r < hdr_r.data_length;

    // ****************************************
    // status quadlet
    // ****************************************
    always_comb begin
        trl_q = 32'h0000_0000;
        if (fmt_r == FMT_STREAM) begin
            ack_fin = err_r ? `ARPF_STRM_BAD : `ARPF_STRM_OK;
        end else if ((fmt_r == FMT_BLOCK) && err_r) begin
            ack_fin = `ARPF_ACK_DATA_ERR;
        end else begin
            // link ack kept verbatim, reserved codes too
            ack_fin = hdr_r.returned_ack_field;
        end
        trl_q[3:0] = ack_fin;
        if (fmt_r != FMT_STREAM) begin
            trl_q[`ARPF_TRL_U_BIT] = hdr_r.unsolicited;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        logic [1:0] b_after;
        b_after = bcnt_r;
        st_nxt = st_r;
        idx_nxt = idx_r;
        sh_nxt = sh_r;
        bcnt_nxt = bcnt_r;
        tot_nxt = tot_r;
        pend_nxt = pend_r;
        done_nxt = done_r;
        err_nxt = err_r;
        emit = 1'b0;
        emit_trl = 1'b0;
        emit_hdr = 1'b0;
        emit_data = 32'h0000_0000;
        case (st_r)
            ST_IDLE: begin
                if (accept) begin
                    st_nxt = ST_HDR;
                    idx_nxt = 2'h0;
                    sh_nxt = 32'h0000_0000;
                    bcnt_nxt = 2'h0;
                    tot_nxt = 16'h0000;
                    pend_nxt = 1'b0;
                    done_nxt = 1'b0;
                    err_nxt = 1'b0;
                end
            end
            ST_HDR: begin
                if (!fifo_full) begin
                    emit = 1'b1;
                    emit_hdr = 1'b1;
                    emit_data = hdr_quad(hdr_r, fmt_r, idx_r);
                    if (idx_r == last_idx(fmt_r)) begin
                        st_nxt = has_pay ? ST_PAY : ST_TRL;
                    end else begin
                        idx_nxt = idx_r + 2'h1;
                    end
                end
            end
            ST_PAY: begin
                if (pend_r) begin
                    if (!fifo_full) begin
                        emit = 1'b1;
                        emit_data = sh_r;
                        sh_nxt = 32'h0000_0000;
                        bcnt_nxt = 2'h0;
                        pend_nxt = 1'b0;
                        if (done_r) begin
                            st_nxt = ST_TRL;
                        end
                    end
                end else if (done_r) begin
                    st_nxt = ST_TRL;
                end else if (take) begin
                    if (stor) begin
                        case (bcnt_r)
                            2'h0: sh_nxt[31:24] = byte_in.data;
                            2'h1: sh_nxt[23:16] = byte_in.data;
                            2'h2: sh_nxt[15:8] = byte_in.data;
                            default: sh_nxt[7:0] = byte_in.data;
                        endcase
                        b_after = bcnt_r + 2'h1;
                        bcnt_nxt = b_after;
                    end
                    if (tot_r != 16'hFFFF) begin
                        tot_nxt = tot_r + 16'h0001;
                    end
                    // untouched low bytes stay zero as padding
                    pend_nxt = (stor && (bcnt_r == 2'h3)) ||
                               (byte_in.last && (b_after != 2'h0));
                    if (byte_in.last) begin
                        done_nxt = 1'b1;
                        err_nxt = byte_in.crc_err ||
                                  ((tot_r + 16'h0001) != hdr_r.data_length);
                    end
                end
            end
            ST_TRL: begin
                if (!fifo_full) begin
                    emit = 1'b1;
                    emit_trl = 1'b1;
                    emit_data = trl_q;
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            idx_r <= 2'h0;
            sh_r <= 32'h0000_0000;
            bcnt_r <= 2'h0;
            tot_r <= 16'h0000;
            pend_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            sh_r <= sh_nxt;
            bcnt_r <= bcnt_nxt;
            tot_r <= tot_nxt;
            pend_r <= pend_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_r <= '0;
            fmt_r <= FMT_NODATA;
        end else if (accept) begin
            hdr_r <= hdr_in;
            fmt_r <= fmt_of(hdr_in.transaction_kind_code);
        end
    end

    // ****************************************
    // handshake and fifo outputs
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_ready <= 1'b0;
            byte_ready <= 1'b0;
            fifo_wr <= 1'b0;
            fifo_data <= 32'h0000_0000;
            wr_trl_r <= 1'b0;
            wr_hdr_r <= 1'b0;
            wr_idx_r <= 2'h0;
        end else begin
            hdr_ready <= (st_nxt == ST_IDLE) && ctrl_en_r && !accept;
            byte_ready <= (st_nxt == ST_PAY) && !pend_nxt && !done_nxt;
            fifo_wr <= emit;
            fifo_data <= emit_data;
            wr_trl_r <= emit_trl;
            wr_hdr_r <= emit_hdr;
            wr_idx_r <= idx_r;
        end
    end

    // ****************************************
    // apb registers and interrupt
    // ****************************************
    assign apb_acc = psel && penable && pready;
    assign apb_wr = apb_acc && pwrite;
    assign ev[`ARPF_EV_STORED] = emit_trl;
    assign ev[`ARPF_EV_DERR] = emit_trl && err_r;
    assign ev[`ARPF_EV_RSVACK] = emit_trl && (fmt_r != FMT_STREAM) && is_rsv_ack(ack_fin);

    always_comb begin
        sts_nxt = sts_r;
        if (apb_wr && (paddr == `ARPF_REG_STAT)) begin
            sts_nxt = sts_r & ~pwdata[`ARPF_EV_W-1:0];
        end
        sts_nxt = sts_nxt | ev;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok(paddr);
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    `ARPF_REG_CTRL: prdata <= {31'h0, ctrl_en_r};
                    `ARPF_REG_STAT: prdata <= {29'h0, sts_r};
                    `ARPF_REG_MASK: prdata <= {29'h0, mask_r};
                    `ARPF_REG_COUNT: prdata <= count_r;
                    `ARPF_REG_LAST: prdata <= {24'h0, last_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_en_r <= `ARPF_CTRL_RST;
            mask_r <= '0;
            sts_r <= '0;
            irq <= 1'b0;
        end else begin
            if (apb_wr && (paddr == `ARPF_REG_CTRL)) begin
                ctrl_en_r <= pwdata[0];
            end
            if (apb_wr && (paddr == `ARPF_REG_MASK)) begin
                mask_r <= pwdata[`ARPF_EV_W-1:0];
            end
            sts_r <= sts_nxt;
            irq <= |(sts_r & mask_r);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= 32'h0000_0000;
            last_r <= 8'h00;
        end else if (emit_trl) begin
            count_r <= count_r + 32'h0000_0001;
            last_r <= {hdr_r.transaction_kind_code, ack_fin};
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_zero_len_skip: assert property (
        (st_r == ST_PAY) |-> (hdr_r.data_length != 16'h0000))
        else $error("payload phase entered with zero byte count");
    a_first_byte_msb: assert property (
        (take && stor && (bcnt_r == 2'h0) && (st_r == ST_PAY) && !pend_r && !done_r)
        |=> (sh_r[31:24] == $past(byte_in.data)))
        else $error("first payload byte not in top byte");
    a_pad_zero: assert property (
        (take && stor && byte_in.last && (bcnt_r == 2'h0) && (st_r == ST_PAY) && !pend_r
         && !done_r) |=> (pend_r && (sh_r[23:0] == 24'h000000)))
        else $error("padding bytes not zero");
    a_unsol_flag: assert property (
        (fifo_wr && wr_trl_r && (fmt_r != FMT_STREAM))
        |-> (fifo_data[`ARPF_TRL_U_BIT] == hdr_r.unsolicited))
        else $error("unsolicited bit wrong");
    a_ack_pass: assert property (
        (fifo_wr && wr_trl_r && ((fmt_r == FMT_NODATA) || (fmt_r == FMT_QUAD)))
        |-> (fifo_data[3:0] == hdr_r.returned_ack_field))
        else $error("ack field altered");
    a_stream_status: assert property (
        (fifo_wr && wr_trl_r && (fmt_r == FMT_STREAM))
        |-> (fifo_data[3:0] == ($past(err_r) ? `ARPF_STRM_BAD : `ARPF_STRM_OK)))
        else $error("stream status wrong");
    a_data_err_ack: assert property (
        (emit_trl && (fmt_r == FMT_BLOCK) && err_r) |=> (fifo_data[3:0] == `ARPF_ACK_DATA_ERR))
        else $error("block data error not reported");
    a_hdr_first: assert property (
        accept |=> ((st_r == ST_HDR) && (idx_r == 2'h0)) ##1 (!fifo_wr || wr_hdr_r))
        else $error("packet does not start with header");
    a_label_kept: assert property (
        (fifo_wr && wr_hdr_r && (wr_idx_r == 2'h0) && (fmt_r != FMT_STREAM))
        |-> (fifo_data[15:10] == hdr_r.transaction_label))
        else $error("transaction label changed");
    a_len_field: assert property (
        (fifo_wr && wr_hdr_r && (wr_idx_r == 2'h3) && (fmt_r == FMT_BLOCK))
        |-> (fifo_data == {hdr_r.data_length, is_lock(hdr_r.transaction_kind_code) ?
                           hdr_r.lock_action_code : 16'h0000}))
        else $error("byte count or lock code wrong");
    a_quad_data: assert property (
        (fifo_wr && wr_hdr_r && (wr_idx_r == 2'h3) && (fmt_r == FMT_QUAD) &&
         (hdr_r.transaction_kind_code != `ARPF_TC_BRD_REQ))
        |-> (fifo_data == hdr_r.quadlet_data))
        else $error("quadlet data wrong");
endmodule : arpf_formatter
`default_nettype wire

// >>> arpf_formatter_end.sv
// closing unit of the receive formatter sources; holds no logic
`default_nettype none
`default_nettype wire

// >>> arpf_link_model.sv
// far-side link model: offers headers and payload bytes
`default_nettype none
module arpf_link_model
    import arpf_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic hdr_ready, // header may be taken
    input wire logic byte_ready, // byte may be taken
    output arpf_hdr_t hdr_in, // header fields
    output logic hdr_valid, // header offered
    output arpf_byte_t byte_in, // payload byte
    output logic byte_valid // byte offered
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hdr_valid = 1'b0;
        byte_valid = 1'b0;
        hdr_in = '0;
        byte_in = '1;
    end
    // released lines show the inverse of the last value
    task automatic send(input arpf_hdr_t h, input int n, input logic bad);
        hdr_valid <= 1'b1;
        hdr_in <= h;
        do @(posedge clk); while (hdr_ready !== 1'b1);
        hdr_valid <= 1'b0;
        hdr_in <= ~h;
        for (int i = 0; i < n; i++) begin
            byte_valid <= 1'b1;
            byte_in <= {8'hA0 + 8'(i), i == n - 1, bad && i == n - 1};
            do @(posedge clk); while (byte_ready !== 1'b1);
        end
        byte_valid <= 1'b0;
        byte_in <= ~byte_in;
    endtask : send
endmodule : arpf_link_model
`default_nettype wire

// >>> arpf_testbench.sv
// self-checking bench of the receive formatter
`default_nettype none
module testbench
    import arpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fifo_full = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, fifo_data, rd;
    logic pready, pslverr, hdr_valid, hdr_ready, byte_valid, byte_ready, fifo_wr, irq, er;
    arpf_hdr_t hdr_in;
    arpf_byte_t byte_in;
    logic [31:0] got[$];
    int fail_count = 0, check_count = 0, cyc = 0;
    arpf_formatter dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hdr_valid(hdr_valid), .hdr_in(hdr_in), .hdr_ready(hdr_ready), .byte_valid(byte_valid),
        .byte_in(byte_in), .byte_ready(byte_ready), .fifo_full(fifo_full), .fifo_wr(fifo_wr),
        .fifo_data(fifo_data), .irq(irq));
    arpf_link_model link (.clk(clk), .hdr_ready(hdr_ready), .byte_ready(byte_ready),
        .hdr_in(hdr_in), .hdr_valid(hdr_valid), .byte_in(byte_in), .byte_valid(byte_valid));
    initial forever #5 clk = ~clk;
    // collects fifo words, cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fifo_wr === 1'b1) got.push_back(fifo_data);
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // ************
    // packet runner
    // ************
    task automatic pkt(input logic [3:0] tc, input logic [5:0] lb, input logic [3:0] ak,
        input logic [15:0] ln, input logic u, input logic bad, input logic [3:0] ea,
        input logic stall);
        arpf_hdr_t h;
        logic [31:0] e[$];
        logic [31:0] w;
        logic rsp;
        h = '{16'hFFC1, lb, 2'h1, tc, 4'h0, 16'hFFC2, 48'hFFFF_F000_0400, 4'h3, 32'hCAFE0123,
            ln, 16'h0002, 2'h1, 6'h2A, 4'h3, u, ak};
        rsp = tc inside {4'h2, 4'h6, 4'h7, 4'hB};
        if (tc == 4'hA) begin
            e.push_back({ln, h.stream_tag, h.stream_channel, tc, h.stream_sync});
        end else begin
            e.push_back({h.dest_id, lb, h.retry_code, tc, h.priority_lvl});
            e.push_back(rsp ? {h.source_id, h.response_code_field, 12'h000}
                : {h.source_id, h.dest_offset[47:32]});
            e.push_back(rsp ? 32'h0 : h.dest_offset[31:0]);
        end
        if (tc inside {4'h0, 4'h6}) e.push_back(h.quadlet_data);
        if (tc inside {4'h1, 4'h5, 4'h7, 4'h9, 4'hB})
            e.push_back({ln, (tc == 4'h9 || tc == 4'hB) ? h.lock_action_code : 16'h0});
        for (int i = 0; i < ((tc == 4'h5) ? 0 : int'(ln)); i += 4) begin
            for (int j = 0; j < 4; j++) w = {w[23:0], (i + j < ln) ? 8'hA0 + 8'(i + j) : 8'h00};
            e.push_back(w);
        end
        e.push_back({15'h0, u && tc != 4'hA, 12'h000, ea});
        got.delete();
        fork
            link.send(h, (tc == 4'h5) ? 0 : int'(ln), bad);
            if (stall) begin
                repeat (4) @(posedge clk);
                fifo_full <= 1'b1;
                repeat (5) @(posedge clk);
                fifo_full <= 1'b0;
            end
        join
        for (int k = 0; k < 100 && got.size() < e.size(); k++) @(posedge clk);
        repeat (4) @(posedge clk);
        check("word count", e.size(), got.size());
        foreach (e[k]) check("fifo word", e[k], k < got.size() ? got[k] : ~e[k]);
    endtask : pkt
    task automatic s_nodata();
        pkt(4'h4, 6'h01, 4'hF, 16'h0, 1'b0, 1'b0, 4'hF, 1'b0);
        pkt(4'h2, 6'h02, 4'h1, 16'h0, 1'b0, 1'b0, 4'h1, 1'b0);
    endtask : s_nodata
    task automatic s_busy();
        logic [3:0] cd[4] = '{4'h4, 4'h5, 4'h6, 4'hE};
        foreach (cd[i])
            pkt(4'h4, 6'(i), cd[i], 16'h0, 1'b0, 1'b0, cd[i], 1'b0);
    endtask : s_busy
    task automatic s_quad();
        pkt(4'h0, 6'h10, 4'h1, 16'h0, 1'b0, 1'b0, 4'h1, 1'b0);
        pkt(4'h6, 6'h11, 4'h1, 16'h0, 1'b0, 1'b0, 4'h1, 1'b0);
        pkt(4'h5, 6'h12, 4'h2, 16'h0010, 1'b0, 1'b0, 4'h2, 1'b0);
    endtask : s_quad
    task automatic s_block();
        pkt(4'h1, 6'h3F, 4'h1, 16'h0006, 1'b0, 1'b0, 4'h1, 1'b1);
        pkt(4'h1, 6'h20, 4'h1, 16'h0000, 1'b0, 1'b0, 4'h1, 1'b0);
        pkt(4'hB, 6'h21, 4'h1, 16'h0004, 1'b1, 1'b1, 4'hD, 1'b0);
    endtask : s_block
    task automatic s_stream();
        pkt(4'hA, 6'h00, 4'h0, 16'h0005, 1'b0, 1'b0, 4'h1, 1'b0);
        pkt(4'hA, 6'h00, 4'h0, 16'h0002, 1'b0, 1'b1, 4'hD, 1'b0);
    endtask : s_stream
    task automatic s_regs();
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl reset", 32'h1, rd);
        apb(1'b0, 12'h004, 32'h0);
        check("status", 32'h7, rd);
        check("mapped err", 32'h0, er);
        apb(1'b0, 12'h00C, 32'h0);
        check("count", 32'hE, rd);
        apb(1'b0, 12'h010, 32'h0);
        check("last", 32'hAD, rd);
        check("irq masked", 32'h0, irq);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge clk);
        check("irq", 32'h1, irq);
        apb(1'b1, 12'h004, 32'h1);
        repeat (2) @(posedge clk);
        check("irq cleared", 32'h0, irq);
        apb(1'b0, 12'h004, 32'h0);
        check("status w1c", 32'h6, rd);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped err", 32'h1, er);
        check("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl off", 32'h0, rd);
        repeat (2) @(posedge clk);
        check("hdr_ready off", 32'h0, hdr_ready);
    endtask : s_regs
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_nodata();
        s_busy();
        s_quad();
        s_block();
        s_stream();
        s_regs();
        summarize();
    end
endmodule : testbench
`default_nettype wire
